// ==== hw/smw_pkg.sv ====
// package: constants, types and state for the mode and watchdog command decoder
// ===========================================================================
// Notes on behaviour
// - refresh register at address field 01_101, data zero
// - word 5a00 restarts the watchdog period
// - refresh moves config or pending-normal to normal
// - mode register field 01_110, selector and inverted code
// - selectors 0_1100..0_1111: regulator off, timer/sense bits
// - selectors 1_0000..1_1111: regulator on, four option bits
// - guard on: low bits equal inverse of code
// - e100 clears can wake, e380 clears io wake
// - e700 and e900 clear the two lin wakes
// - pending wake flag: enter then wake at once
// - e180 clears both can failure flags
// - 5c10 wakes from regulator-on low power
// - global commands: mode address, bits 15-14, bit 8 set
// - globals report mode, debug, safe; give code
// - 1d00/1d80 return three random bits low
// - bit 7 set turns safe output off
package smw_pkg;

  // ===========================================================================
  // frame fields and addresses
  localparam int          FRAME_BITS    = 16;
  localparam logic [4:0]  ADDR_WATCHDOG = 5'h0d;
  localparam logic [4:0]  ADDR_MODE     = 5'h0e;
  localparam logic [15:0] CMD_REFRESH   = 16'h5a00;
  localparam logic [15:0] CMD_WAKE_NORM = 16'h5c10;
  localparam logic [15:0] CMD_CLR_CAN   = 16'he100;
  localparam logic [15:0] CMD_CLR_IO    = 16'he380;
  localparam logic [15:0] CMD_CLR_LIN1  = 16'he700;
  localparam logic [15:0] CMD_CLR_LIN2  = 16'he900;
  localparam logic [15:0] CMD_RD_CANF   = 16'he180;
  localparam logic [1:0]  GLB_PLAIN     = 2'h0;
  localparam logic [1:0]  GLB_DEBUG     = 2'h3;
  localparam logic [1:0]  WR_PREFIX     = 2'h1;
  localparam logic [4:0]  SEL_LP_OFF_LO = 5'h0c;
  localparam logic [4:0]  SEL_LP_ON_LO  = 5'h10;
  localparam logic [4:0]  SEL_NORMAL_RQ = 5'h02;

  // ===========================================================================
  // operating phases, coded as they read back in the status byte
  typedef enum logic [4:0] {
    PH_INIT    = 5'b00000,
    PH_FLASH   = 5'b00001,
    PH_PENDING = 5'b00010,
    PH_NORMAL  = 5'b00011,
    PH_LP_OFF  = 5'b01100,
    PH_LP_ON   = 5'b10000
  } smw_phase_t;

  // low-power options chosen by the last accepted low-power mode write
  typedef struct packed {
    logic forced_wakeup_timer;
    logic cyclic_sense;
    logic cyclic_int;
    logic lp_watchdog;
  } smw_lp_opts_t;

  // wake and failure flags
  typedef struct packed {
    logic can_wake;
    logic io_wake;
    logic lin1_wake;
    logic lin2_wake;
    logic can_failure;
    logic can_secondary_failure_flag;
  } smw_flags_t;

  // one received frame, handed between clock domains
  typedef struct packed {
    logic [15:0] word;
  } smw_frame_t;

  // decoding of a mode selector, used by the command decode only
  function automatic logic smw_is_lp_off(input logic [4:0] sel);
    smw_is_lp_off = (sel[4:2] == SEL_LP_OFF_LO[4:2]);
  endfunction : smw_is_lp_off

  function automatic logic smw_is_lp_on(input logic [4:0] sel);
    smw_is_lp_on = sel[4];
  endfunction : smw_is_lp_on

endpackage : smw_pkg

// ==== hw/smw_shift_rx.sv ====
// serial receiver: shifts a 16-bit frame in on the link clock
`timescale 1ns/1ns
module smw_shift_rx (
  input  wire logic                sclk_in,
  input  wire logic                rst_in,
  input  wire logic                cs_n_in,
  input  wire logic                mosi_in,
  input  wire logic [15:0]         reply_in,
  output logic                     miso_out,
  output smw_pkg::smw_frame_t      frame_out,
  output logic                     toggle_out
);
  import smw_pkg::*;

  // per-frame state, cleared whenever the frame is deselected
  typedef struct packed {
    logic [15:0] shift;
    logic [4:0]  count;
    logic [15:0] tx;
  } smw_rx_state_t;

  // state that must survive between frames
  typedef struct packed {
    smw_frame_t  frame;
    logic        toggle;
  } smw_rx_hold_t;

  smw_rx_state_t st;
  smw_rx_state_t next_st;
  smw_rx_hold_t  hold;
  smw_rx_hold_t  next_hold;
  logic          frame_clr;

  // the link clock stops between frames, so deselect must clear the counter
  // by itself; otherwise a cut frame would shift the next one out of step
  assign frame_clr = rst_in | cs_n_in;

  // ===========================================================================
  // shift in msb first; a frame counts only when all sixteen bits arrived
  always_comb
  begin
    next_st       = st;
    next_hold     = hold;
    next_st.shift = {st.shift[14:0], mosi_in};
    // reply is launched on the first rising edge; the host takes each bit on the falling edge
    if (st.count == 5'h00)
      next_st.tx = reply_in;
    else
      next_st.tx = {st.tx[14:0], 1'b0};
    if (st.count == 5'(FRAME_BITS - 1))
    begin
      next_hold.frame.word = {st.shift[14:0], mosi_in};
      next_hold.toggle     = ~hold.toggle;
      next_st.count        = 5'h00;
    end
    else
      next_st.count = st.count + 5'h01;
  end

  // ===========================================================================
  // frame-scoped registers, cleared asynchronously by deselect
  always_ff @(posedge sclk_in or posedge frame_clr)
  begin
    if (frame_clr)
      st <= '0;
    else
      st <= next_st;
  end

  // the toggle carries the frame event across to the core clock
  always_ff @(posedge sclk_in or posedge rst_in)
  begin
    if (rst_in)
      hold <= '0;
    else
      hold <= next_hold;
  end

  assign miso_out   = st.tx[15];
  assign frame_out  = hold.frame;
  assign toggle_out = hold.toggle;
endmodule : smw_shift_rx

// ==== hw/smw_random_code.sv ====
// free-running pseudo-random source for the low-power guard code
`timescale 1ns/1ns
module smw_random_code (
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  output logic [2:0]      code_out
);
  import smw_pkg::*;

  typedef struct packed {
    logic [7:0] lfsr;
  } smw_rng_state_t;

  smw_rng_state_t st;
  smw_rng_state_t next_st;

  // ===========================================================================
  // eight-bit maximal lfsr; cheap, and only has to defeat runaway writes
  always_comb
  begin
    next_st      = st;
    next_st.lfsr = {st.lfsr[6:0], st.lfsr[7] ^ st.lfsr[5] ^ st.lfsr[4] ^ st.lfsr[3]};
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      st <= '{lfsr: 8'h01};
    else
      st <= next_st;
  end

  assign code_out = st.lfsr[2:0];
endmodule : smw_random_code

// ==== hw/smw_mode_wd_decoder.sv ====
// mode and watchdog command decoder: link receiver, crossing and decode
`timescale 1ns/1ns
module smw_mode_wd_decoder (
  input  wire logic                  clock_in,
  input  wire logic                  rst_in,
  input  wire logic                  sclk_in,
  input  wire logic                  cs_n_in,
  input  wire logic                  mosi_in,
  output logic                       miso_out,
  input  wire logic                  guard_enable_in,
  input  wire logic                  debug_in,
  input  wire logic                  set_can_wake_in,
  input  wire logic                  set_io_wake_in,
  input  wire logic                  set_lin1_wake_in,
  input  wire logic                  set_lin2_wake_in,
  input  wire logic                  set_can_fail_in,
  input  wire logic                  set_can_fail2_in,
  input  wire logic                  wake_event_in,
  output logic                       wd_restart_out,
  output smw_pkg::smw_phase_t        phase_out,
  output smw_pkg::smw_lp_opts_t      lp_opts_out,
  output smw_pkg::smw_flags_t        flags_out,
  output logic                       safe_on_out,
  output logic                       debug_out,
  output logic                       wake_out
);
  import smw_pkg::*;

  // ===========================================================================
  // core state: everything the system clock owns
  typedef struct packed {
    logic [2:0]   tog_sync;
    logic [1:0]   guard_sync;
    logic [1:0]   debug_sync;
    logic [1:0]   wake_sync;
    smw_frame_t   frame;
    logic         frame_valid;
    logic         frame_valid_d;
    smw_phase_t   phase;
    smw_lp_opts_t opts;
    smw_flags_t   flags;
    logic [2:0]   rnd_held;
    logic         safe_on;
    logic         debug_active;
    logic         debug_left;
    logic         wd_restart;
    logic         wake;
    logic [15:0]  reply;
  } smw_core_state_t;

  smw_core_state_t st;
  smw_core_state_t next_st;

  smw_frame_t  rx_frame;
  logic        rx_toggle;
  logic [2:0]  rnd_code;

  // reply is taken by the link side at the first rising edge of a frame,
  // when the core has long since settled it
  smw_shift_rx u_rx (
    .sclk_in    (sclk_in),
    .rst_in     (rst_in),
    .cs_n_in    (cs_n_in),
    .mosi_in    (mosi_in),
    .reply_in   (st.reply),
    .miso_out   (miso_out),
    .frame_out  (rx_frame),
    .toggle_out (rx_toggle)
  );

  smw_random_code u_rng (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .code_out (rnd_code)
  );

  // ===========================================================================
  // decode helpers
  function automatic logic is_global(input logic [15:0] w);
    is_global = (w[13:9] == ADDR_MODE) && w[8] &&
                (w[15:14] == GLB_PLAIN || w[15:14] == GLB_DEBUG) && (w[6:0] == 7'h00);
  endfunction : is_global

  logic [15:0] w;
  logic        mode_write;
  logic [4:0]  sel;
  logic        guard_ok;
  logic        any_wake;
  logic        new_frame;

  always_comb
  begin
    w          = st.frame.word;
    new_frame  = st.frame_valid & ~st.frame_valid_d;
    sel        = w[7:3];
    mode_write = (w[15:14] == WR_PREFIX) && (w[13:9] == ADDR_MODE) && !w[8];
    guard_ok   = !st.guard_sync[1] || (w[2:0] == ~st.rnd_held);
    any_wake   = st.flags.can_wake | st.flags.io_wake | st.flags.lin1_wake | st.flags.lin2_wake;
  end

  // ===========================================================================
  // next-state logic
  always_comb
  begin
    next_st               = st;
    next_st.tog_sync      = {st.tog_sync[1:0], rx_toggle};
    next_st.guard_sync    = {st.guard_sync[0], guard_enable_in};
    next_st.debug_sync    = {st.debug_sync[0], debug_in};
    next_st.wake_sync     = {st.wake_sync[0], wake_event_in};
    next_st.frame_valid   = 1'b0;
    next_st.frame_valid_d = st.frame_valid;
    next_st.wd_restart    = 1'b0;
    next_st.wake          = 1'b0;
    next_st.debug_active  = st.debug_sync[1] & ~st.debug_left;

    // frame word is stable in the link domain long before its toggle lands
    if (st.tog_sync[2] != st.tog_sync[1])
    begin
      next_st.frame       = rx_frame;
      next_st.frame_valid = 1'b1;
    end

    // flag sources: setting wins over a clear in the same cycle
    if (new_frame && w == CMD_CLR_CAN)
      next_st.flags.can_wake = 1'b0;
    if (new_frame && w == CMD_CLR_IO)
      next_st.flags.io_wake = 1'b0;
    if (new_frame && w == CMD_CLR_LIN1)
      next_st.flags.lin1_wake = 1'b0;
    if (new_frame && w == CMD_CLR_LIN2)
      next_st.flags.lin2_wake = 1'b0;
    if (new_frame && w == CMD_RD_CANF)
    begin
      next_st.flags.can_failure                = 1'b0;
      next_st.flags.can_secondary_failure_flag = 1'b0;
    end
    next_st.flags.can_wake  = next_st.flags.can_wake  | set_can_wake_in;
    next_st.flags.io_wake   = next_st.flags.io_wake   | set_io_wake_in;
    next_st.flags.lin1_wake = next_st.flags.lin1_wake | set_lin1_wake_in;
    next_st.flags.lin2_wake = next_st.flags.lin2_wake | set_lin2_wake_in;
    next_st.flags.can_failure = next_st.flags.can_failure | set_can_fail_in;
    next_st.flags.can_secondary_failure_flag =
      next_st.flags.can_secondary_failure_flag | set_can_fail2_in;

    // phase and command decode
    if (new_frame)
    begin
      if (w == CMD_REFRESH)
      begin
        next_st.wd_restart = 1'b1;
        if (st.phase == PH_INIT || st.phase == PH_PENDING)
          next_st.phase = PH_NORMAL;
      end
      else if (w == CMD_WAKE_NORM && st.phase == PH_LP_ON)
      begin
        next_st.phase = PH_PENDING;
        next_st.wake  = 1'b1;
      end
      else if (is_global(w))
      begin
        // a fresh code is latched for the following low-power write
        next_st.rnd_held = rnd_code;
        if (w[7])
          next_st.safe_on = 1'b0;
        else if (w[15:14] == GLB_PLAIN || w[15:14] == GLB_DEBUG)
          next_st.debug_left = 1'b1;
      end
      else if (mode_write && st.phase == PH_NORMAL && guard_ok)
      begin
        if (smw_is_lp_on(sel))
        begin
          next_st.phase = PH_LP_ON;
          next_st.opts  = '{forced_wakeup_timer: sel[3], cyclic_sense: sel[2],
                            cyclic_int: sel[1], lp_watchdog: sel[0]};
        end
        else if (smw_is_lp_off(sel))
        begin
          next_st.phase = PH_LP_OFF;
          next_st.opts  = '{forced_wakeup_timer: sel[1], cyclic_sense: sel[0],
                            cyclic_int: 1'b0, lp_watchdog: 1'b0};
        end
        else if (sel == SEL_NORMAL_RQ)
          next_st.phase = PH_PENDING;
      end
    end

    // a wake flag left standing, or an outside wake, ends low power at once
    if ((st.phase == PH_LP_ON || st.phase == PH_LP_OFF) && (any_wake || st.wake_sync[1]))
    begin
      next_st.phase = PH_PENDING;
      next_st.wake  = 1'b1;
    end

    // status word for the next frame: fixed status, current mode, low bits
    // the held code stands until the next global read, so the host sees the same code the guard uses
    next_st.reply = {8'h00, 5'(st.phase), st.rnd_held};
    if (is_global(st.frame.word) && st.frame.word[15:14] == GLB_DEBUG)
      next_st.reply[2:0] = {1'b0, st.safe_on, st.debug_active};
  end

  // ===========================================================================
  // register the whole core state; safe output comes up driven
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st         <= '0;
      st.phase   <= PH_INIT;
      st.safe_on <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign wd_restart_out = st.wd_restart;
  assign phase_out      = st.phase;
  assign lp_opts_out    = st.opts;
  assign flags_out      = st.flags;
  assign safe_on_out    = st.safe_on;
  assign debug_out      = st.debug_active;
  assign wake_out       = st.wake;
endmodule : smw_mode_wd_decoder

// ==== bench/smw_decoder_checker.sv ====
// checker: concurrent assertions on the decoder's top-level outputs
`timescale 1ns/1ns
module smw_decoder_checker
  import smw_pkg::*;
(
  input wire logic              clock_in,
  input wire logic              rst_in,
  input wire logic              set_can_wake_in,
  input wire logic              wd_restart_out,
  input smw_pkg::smw_phase_t    phase_out,
  input smw_pkg::smw_lp_opts_t  lp_opts_out,
  input smw_pkg::smw_flags_t    flags_out,
  input wire logic              safe_on_out,
  input wire logic              wake_out
);
  // ===========================================================================
  // one domain only, so clock and reset are given once
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  // a phase that was held last cycle has just been left
  sequence s_left(smw_phase_t p);
    $past(phase_out) == p && phase_out != p;
  endsequence
  // entry into either low-power phase
  sequence s_lp_entry;
    $changed(phase_out) && (phase_out inside {PH_LP_OFF, PH_LP_ON});
  endsequence

  chk_restart_single: assert property (wd_restart_out |=> !wd_restart_out)
    else $error("restart pulse longer than one cycle");
  chk_init_to_normal: assert property (s_left(PH_INIT) |-> phase_out == PH_NORMAL)
    else $error("init phase left to a phase other than normal");
  chk_lp_from_normal: assert property (s_lp_entry |-> $past(phase_out) == PH_NORMAL)
    else $error("low-power phase entered from a phase other than normal");
  chk_lpon_wake_pending: assert property (s_left(PH_LP_ON) |-> phase_out == PH_PENDING)
    else $error("regulator-on low power left to a phase other than pending");
  chk_wake_single: assert property (wake_out |=> !wake_out)
    else $error("wake pulse longer than one cycle");
  chk_flag_set_seen: assert property (set_can_wake_in |-> ##[1:2] flags_out.can_wake)
    else $error("can wake flag not set");
  chk_safe_never_on: assert property (!$rose(safe_on_out))
    else $error("safe output turned back on");
  chk_regoff_opts: assert property (phase_out == PH_LP_OFF |-> !lp_opts_out.cyclic_int && !lp_opts_out.lp_watchdog)
    else $error("regulator-off mode shows regulator-on options");
  chk_phase_legal: assert property (phase_out inside {PH_INIT, PH_FLASH, PH_PENDING, PH_NORMAL, PH_LP_OFF, PH_LP_ON})
    else $error("phase code outside the defined set");
endmodule : smw_decoder_checker

bind smw_mode_wd_decoder smw_decoder_checker smw_decoder_checker_i (.clock_in(clock_in), .rst_in(rst_in),
  .set_can_wake_in(set_can_wake_in), .wd_restart_out(wd_restart_out), .phase_out(phase_out),
  .lp_opts_out(lp_opts_out), .flags_out(flags_out), .safe_on_out(safe_on_out), .wake_out(wake_out));

// ==== bench/smw_host_model.sv ====
// host model: serial master that sends command frames and captures replies
`timescale 1ns/1ns
module smw_host_model (
  output logic       sclk_out,
  output logic       cs_n_out,
  output logic       mosi_out,
  input  wire logic  miso_in
);
  // ===========================================================================
  // link clock stands still low outside frames
  initial
  begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end

  // bare link edges with the frame deselected, needed around reset
  task automatic pulses(input int n);
    repeat (n)
    begin
      #32 sclk_out = 1'b1;
      #32 sclk_out = 1'b0;
    end
  endtask : pulses

  // frame of 'bits' bits, msb first, 64 ns link period; short counts make partial frames
  task automatic xfer(input logic [15:0] word, input int bits, output logic [15:0] reply);
    int i;
    reply = 16'h0000;
    #3 cs_n_out = 1'b0;
    for (i = 15; i > 15 - bits; i--)
    begin
      mosi_out = word[i];
      #32 sclk_out = 1'b1;
      // reply bit is launched on the rising edge and taken on the falling one
      #32 reply[i] = miso_in;
      sclk_out = 1'b0;
    end
    // released data line shows the inverse so a stale bit never looks valid
    mosi_out = ~mosi_out;
    cs_n_out = 1'b1;
    #200; // gap covers the 8-cycle spacing and the decode latency
  endtask : xfer
endmodule : smw_host_model

// ==== bench/sbc_mode_watchdog_command_decoder_tb_top.sv ====
// testbench: command frames through the host model, checks of decoder outputs
`timescale 1ns/1ns
module sbc_mode_watchdog_command_decoder_tb_top;
  import smw_pkg::*;
  logic         clock_in, rst_in, sclk, cs_n, mosi, miso, guard_en, dbg, wake_ev;
  logic         wd_restart, safe_on, dbg_out, wake;
  logic [5:0]   set_f;
  logic [15:0]  rep;
  logic [2:0]   code;
  smw_phase_t   phase;
  smw_lp_opts_t opts;
  smw_flags_t   flags;
  int           num_errors, comparisons, n_restart, n_wake, m, i;
  logic [15:0]  clr_cmd [5] = '{CMD_CLR_CAN, CMD_CLR_IO, CMD_CLR_LIN1, CMD_CLR_LIN2, CMD_RD_CANF};
  logic [15:0]  left [5] = '{16'h001f, 16'h000f, 16'h0007, 16'h0003, 16'h0000};

  // ===========================================================================
  // instances
  smw_mode_wd_decoder smw_mode_wd_decoder_i (.clock_in(clock_in), .rst_in(rst_in), .sclk_in(sclk),
    .cs_n_in(cs_n), .mosi_in(mosi), .miso_out(miso), .guard_enable_in(guard_en), .debug_in(dbg),
    .set_can_wake_in(set_f[5]), .set_io_wake_in(set_f[4]), .set_lin1_wake_in(set_f[3]),
    .set_lin2_wake_in(set_f[2]), .set_can_fail_in(set_f[1]), .set_can_fail2_in(set_f[0]),
    .wake_event_in(wake_ev), .wd_restart_out(wd_restart), .phase_out(phase), .lp_opts_out(opts),
    .flags_out(flags), .safe_on_out(safe_on), .debug_out(dbg_out), .wake_out(wake));
  smw_host_model smw_host_model_i (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso));

  // ===========================================================================
  // clock and pulse counters; counters read the pre-edge value, so no race
  initial
  begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  always @(posedge clock_in)
  begin
    if (wd_restart === 1'b1) n_restart++;
    if (wake === 1'b1) n_wake++;
  end

  // ===========================================================================
  // shared tasks
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic send(input logic [15:0] w);
    @(negedge clock_in);
    smw_host_model_i.xfer(w, 16, rep);
  endtask : send

  // wake by frame (regulator on) or by the wake input, then refresh back to normal
  task automatic to_normal(input logic by_frame);
    m = n_wake;
    if (by_frame)
    begin
      send(CMD_WAKE_NORM);
      check("phase after wake frame", 16'(PH_PENDING), 16'(phase));
    end
    else
    begin
      @(negedge clock_in) wake_ev = 1'b1;
      repeat (4) @(negedge clock_in);
      wake_ev = 1'b0;
      repeat (20) @(negedge clock_in);
    end
    check("wake pulses", 16'h0001, 16'(n_wake - m));
    send(CMD_REFRESH);
    check("phase after refresh", 16'(PH_NORMAL), 16'(phase));
  endtask : to_normal

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  // ===========================================================================
  // watchdog: the sequence needs well under 200 us
  initial
  begin
    #400_000;
    num_errors++;
    results();
  end

  // ===========================================================================
  // main sequence
  initial
  begin
    rst_in = 1'b1;
    {guard_en, dbg, wake_ev, set_f} = 9'h000;
    {num_errors, comparisons, n_restart, n_wake} = 128'h0;
    smw_host_model_i.pulses(2);
    repeat (10) @(posedge clock_in);
    @(negedge clock_in) rst_in = 1'b0;
    smw_host_model_i.pulses(2);
    check("reset phase", 16'(PH_INIT), 16'(phase));
    check("reset safe and restart", 16'h0002, {14'h0000, safe_on, wd_restart});
    $display("test reset done");
    m = n_restart;
    @(negedge clock_in) smw_host_model_i.xfer(CMD_REFRESH, 8, rep);
    check("partial frame restarts", 16'h0000, 16'(n_restart - m));
    send(CMD_REFRESH);
    check("restart pulses", 16'h0001, 16'(n_restart - m));
    check("phase after refresh", 16'(PH_NORMAL), 16'(phase));
    $display("test refresh done");
    @(negedge clock_in) dbg = 1'b1;
    repeat (4) @(negedge clock_in);
    check("debug active", 16'h0001, 16'(dbg_out));
    send(16'hdd00);
    check("debug left", 16'h0000, 16'(dbg_out));
    send(CMD_REFRESH);
    check("status reply", 16'({PH_NORMAL, 3'b010}), 16'(rep[7:0]));
    send(16'h1d00);
    check("safe kept", 16'h0001, 16'(safe_on));
    send(16'h1d80);
    check("safe released", 16'h0000, 16'(safe_on));
    send(CMD_REFRESH);
    check("mode reply", 16'(PH_NORMAL), 16'(rep[7:3]));
    $display("test global reads done");
    @(negedge clock_in) set_f = 6'h3f;
    @(negedge clock_in) set_f = 6'h00;
    repeat (3) @(negedge clock_in);
    check("flags set", 16'h003f, 16'(flags));
    for (i = 0; i < 5; i++)
    begin
      send(clr_cmd[i]);
      check("flags after clear", left[i], 16'(flags));
    end
    $display("test flags done");
    for (i = 12; i < 16; i++)
    begin
      send({WR_PREFIX, ADDR_MODE, 1'b0, 5'(i), 3'b000});
      check("regulator-off phase", 16'(PH_LP_OFF), 16'(phase));
      check("regulator-off options", 16'({i[1:0], 2'b00}), 16'(opts));
      to_normal(1'b0);
    end
    $display("test regulator-off modes done");
    @(negedge clock_in) guard_en = 1'b1;
    repeat (4) @(negedge clock_in);
    send(16'h1d00);
    send(CMD_REFRESH);
    code = rep[2:0];
    send({WR_PREFIX, ADDR_MODE, 1'b0, SEL_LP_OFF_LO, code});
    check("phase after bad code", 16'(PH_NORMAL), 16'(phase));
    send(16'h1d00);
    send(CMD_REFRESH);
    code = rep[2:0];
    send({WR_PREFIX, ADDR_MODE, 1'b0, SEL_LP_OFF_LO, ~code});
    check("phase after good code", 16'(PH_LP_OFF), 16'(phase));
    to_normal(1'b0);
    @(negedge clock_in) guard_en = 1'b0;
    $display("test guard done");
    for (i = 16; i < 32; i++)
    begin
      send({WR_PREFIX, ADDR_MODE, 1'b0, 5'(i), 3'b000});
      check("regulator-on phase", 16'(PH_LP_ON), 16'(phase));
      check("regulator-on options", 16'(i[3:0]), 16'(opts));
      to_normal(1'b1);
    end
    $display("test regulator-on modes done");
    @(negedge clock_in) set_f = 6'h20;
    @(negedge clock_in) set_f = 6'h00;
    m = n_wake;
    send({WR_PREFIX, ADDR_MODE, 1'b0, SEL_LP_ON_LO, 3'b000});
    check("wake on pending flag", 16'h0001, 16'(n_wake - m));
    check("phase on pending flag", 16'(PH_PENDING), 16'(phase));
    send(CMD_CLR_CAN);
    check("flags after pending clear", 16'h0000, 16'(flags));
    $display("test pending flag done");
    results();
  end
endmodule : sbc_mode_watchdog_command_decoder_tb_top
